// [rtl/iocs_map.svh]
// I/O chip-select decoder: port offsets, field positions, reset values and
// fixed address ranges. Included by the package and the design modules.
`ifndef IOCS_MAP_SVH
`define IOCS_MAP_SVH

// configuration ports on the host I/O space (full 16-bit decode)
`define IOCS_PERIPH_CFG_PORT 16'h2872
`define IOCS_SERIAL_CFG_PORT 16'h2072
`define IOCS_SYS_CTRL_PORT 16'h0092
`define IOCS_RTC_INDEX_PORT 16'h0070
`define IOCS_RTC_DATA_PORT 16'h0071

// reset values
`define IOCS_PERIPH_CFG_RESET 16'h0000
`define IOCS_SERIAL_CFG_RESET 8'h00

// peripheral_select_config field positions
`define IOCS_RTC_LOC_BIT 15
`define IOCS_FAST_VIDEO_BIT 14
`define IOCS_FAST_SCSI_BIT 13
`define IOCS_WIN_EN_BIT 12
`define IOCS_WIN_UPPER_BIT 11
`define IOCS_WIN_LMASK_HI 10
`define IOCS_WIN_LMASK_LO 8
`define IOCS_WIN_LOC_BIT 7
`define IOCS_HS_DISK_BIT 6
`define IOCS_DECODE16_BIT 5
`define IOCS_PRI_SEC_BIT 4
`define IOCS_LOCK_INH_BIT 2
`define IOCS_HD_DIS_BIT 1
`define IOCS_FLP_DIS_BIT 0
// writable bits: bit 3 is reserved and reads zero
`define IOCS_PERIPH_CFG_MASK 16'hfff7

// serial_port_select_low field positions
`define IOCS_FIRST_SERIAL_SELECT_HI 7
`define IOCS_FIRST_SERIAL_SELECT_LO 5
`define IOCS_FIRST_SERIAL_SELECT_LOC_BIT 4
`define IOCS_SECOND_SERIAL_SELECT_HI 3
`define IOCS_SECOND_SERIAL_SELECT_LO 1
`define IOCS_SECOND_SERIAL_SELECT_LOC_BIT 0

// serial port bases, eight bytes each
`define IOCS_SER_BASE_1 16'h03f8
`define IOCS_SER_BASE_2 16'h02f8
`define IOCS_SER_BASE_3 16'h03e8
`define IOCS_SER_BASE_4 16'h02e8
`define IOCS_SER_IGN 4'h3

// fixed device ranges
`define IOCS_RTC_BASE 16'h0070
`define IOCS_VIDEO_BASE_A 16'h03c0
`define IOCS_VIDEO_BASE_B 16'h03c4
`define IOCS_VIDEO_BASE_C 16'h03ce
`define IOCS_SCSI_BASE 16'h3530
`define IOCS_HD_CMD_PRI 16'h01f0
`define IOCS_HD_CMD_SEC 16'h0170
`define IOCS_HD_CTL_PRI 16'h03f6
`define IOCS_HD_CTL_SEC 16'h0376
`define IOCS_FLP_PRI 16'h03f0
`define IOCS_FLP_SEC 16'h0370
`define IOCS_PSW_LO 7'h38
`define IOCS_PSW_HI 7'h3f
`define IOCS_LOCK_DATA_BIT 3

// wait-state codes; zero leaves the cycle at its normal timing
`define IOCS_WS_NORMAL 3'h0
`define IOCS_WS_ONE 3'h1
`define IOCS_WS_FOUR 3'h4

`endif

// [rtl/iocs_pkg.sv]
// I/O chip-select decoder types and the shared address-match function.
// Assumes iocs_map.svh is on the include path.
`include "iocs_map.svh"

package iocs_pkg;

    // one host I/O cycle as seen by the decoder
    typedef struct packed {
        logic active;
        logic write;
        logic byte8;
        logic [15:0] addr;
        logic [15:0] wdata;
    } iocs_cycle_t;

    // chip selects, active high
    typedef struct packed {
        logic floppy;
        logic hd_cmd;
        logic hd_ctl;
        logic serial_a;
        logic serial_b;
        logic window;
        logic rtc;
        logic video;
    } iocs_cs_t;

    // address hit: ign low bits are don't-care, A15:10 only when upper set
    function automatic logic io_match(input logic [15:0] a,
                                      input logic [15:0] base,
                                      input logic [3:0] ign,
                                      input logic upper);
        logic [15:0] m;
        m = 16'hffff << ign;
        if (!upper)
            m[15:10] = 6'h00;
        return ((a ^ base) & m) == 16'h0000;
    endfunction

endpackage

// [rtl/iocs_serial_dec.sv]
// Serial-port chip-select range decode from a 3-bit select field.
// Assumes a combinational consumer that registers the hit.
`timescale 1ns/1ps
`include "iocs_map.svh"

module iocs_serial_dec
(
    input wire logic [2:0] sel,
    input wire logic [15:0] addr,
    input wire logic full_decode,
    output logic hit
);
    logic [15:0] base;

    always_comb
    begin
        base = `IOCS_SER_BASE_1;
        hit = 1'b0;
        case (sel)
            3'h1: base = `IOCS_SER_BASE_1;
            3'h2: base = `IOCS_SER_BASE_2;
            3'h3: base = `IOCS_SER_BASE_3;
            3'h4: base = `IOCS_SER_BASE_4;
            default: base = `IOCS_SER_BASE_1;
        endcase
        // codes above 100 are treated like 000: no select
        if (sel != 3'h0 && sel <= 3'h4)
            hit = iocs_pkg::io_match(addr, base, `IOCS_SER_IGN, full_decode);
    end
endmodule

// [rtl/iocs_window_dec.sv]
// Programmable window decode; the base address comes from outside.
// Assumes the base register is held by neighbouring logic.
`timescale 1ns/1ps
`include "iocs_map.svh"

module iocs_window_dec
(
    input wire logic [15:0] addr,
    input wire logic [15:0] base,
    input wire logic enable,
    input wire logic upper_compare,
    input wire logic [2:0] lower_mask,
    output logic hit
);
    logic [3:0] ign;

    always_comb
    begin
        ign = 4'h0;
        case (lower_mask)
            3'h1: ign = 4'h1;
            3'h2: ign = 4'h2;
            3'h3: ign = 4'h3;
            3'h4: ign = 4'h4;
            default: ign = 4'h0;
        endcase
        hit = enable && iocs_pkg::io_match(addr, base, ign, upper_compare);
    end
endmodule

// [rtl/iocs_decoder.sv]
// I/O port chip-select decoder top: config ports, selects, steering,
// wait states, high-speed disk and password lock.
// Assumes cycle fields come from logic on clk; no synchronisers needed.
`timescale 1ns/1ps
`include "iocs_map.svh"

// Overview of operation
// - serial A field picks one of four ranges
// - serial A location bit steers bus
// - serial B is chip select 10
// - serial B field picks one of four ranges
// - serial B location bit steers bus
// - rtc location bit steers bus
// - fast video gives one wait state
// - fast scsi: one wait, else four
// - window enable gates chip select 11
// - upper compare includes A15:10 in window
// - lower mask drops low window bits
// - window location bit steers bus
// - high-speed disk compresses later transfers
// - decode width bit picks 10 or 16
// - primary/secondary picks disk addresses
// - password lock blocks cmos bytes 38-3f
// - inhibit stops later lock setting
// - hard disk disable stops disk selects
// - floppy disable stops floppy select
module iocs_decoder
(
    input wire logic clk,
    input wire logic reset,
    input iocs_pkg::iocs_cycle_t cycle,
    input wire logic [15:0] window_base,
    output iocs_pkg::iocs_cs_t cs,
    output logic expansion_bus_sel,
    output logic [2:0] wait_states,
    output logic compressed_timing,
    output logic ignore_iocs16,
    output logic access_blocked,
    output logic [15:0] io_rdata,
    output logic io_rdata_valid
);
    logic [15:0] periph_cfg_reg, periph_cfg_next;
    logic [7:0] serial_cfg_reg, serial_cfg_next;
    logic lock_reg, lock_next;
    logic [6:0] rtc_index_reg, rtc_index_next;
    logic hd_streak_reg, hd_streak_next;
    iocs_pkg::iocs_cs_t cs_reg, cs_next;
    logic exp_reg, exp_next;
    logic [2:0] ws_reg, ws_next;
    logic comp_reg, comp_next;
    logic ign16_reg, ign16_next;
    logic blocked_reg, blocked_next;
    logic [15:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;

    logic full_dec, pri_sec, hit_a, hit_b, hit_win;
    logic [15:0] a;
    logic psw_hit, hd_data, scsi_hit, video_hit;

    assign a = cycle.addr;
    assign full_dec = periph_cfg_reg[`IOCS_DECODE16_BIT];
    assign pri_sec = periph_cfg_reg[`IOCS_PRI_SEC_BIT];

    iocs_serial_dec u_first_serial_select
    (
        .sel(serial_cfg_reg[`IOCS_FIRST_SERIAL_SELECT_HI:`IOCS_FIRST_SERIAL_SELECT_LO]),
        .addr(a),
        .full_decode(full_dec),
        .hit(hit_a)
    );

    // serial B drives chip select 10; overlap with A is software's duty
    iocs_serial_dec u_second_serial_select
    (
        .sel(serial_cfg_reg[`IOCS_SECOND_SERIAL_SELECT_HI:`IOCS_SECOND_SERIAL_SELECT_LO]),
        .addr(a),
        .full_decode(full_dec),
        .hit(hit_b)
    );

    iocs_window_dec u_window
    (
        .addr(a),
        .base(window_base),
        .enable(periph_cfg_reg[`IOCS_WIN_EN_BIT]),
        .upper_compare(periph_cfg_reg[`IOCS_WIN_UPPER_BIT]),
        .lower_mask(periph_cfg_reg[`IOCS_WIN_LMASK_HI:`IOCS_WIN_LMASK_LO]),
        .hit(hit_win)
    );

    // configuration and lock state
    always_comb
    begin
        periph_cfg_next = periph_cfg_reg;
        serial_cfg_next = serial_cfg_reg;
        lock_next = lock_reg;
        rtc_index_next = rtc_index_reg;
        rdata_next = 16'h0000;
        rvalid_next = 1'b0;
        if (cycle.active && cycle.write)
        begin
            if (a == `IOCS_PERIPH_CFG_PORT)
                periph_cfg_next = cycle.wdata & `IOCS_PERIPH_CFG_MASK;
            if (a == `IOCS_SERIAL_CFG_PORT)
                serial_cfg_next = cycle.wdata[7:0];
            if (a == `IOCS_RTC_INDEX_PORT)
                rtc_index_next = cycle.wdata[6:0];
            // lock is sticky until reset; inhibit only blocks setting it
            if (a == `IOCS_SYS_CTRL_PORT && cycle.wdata[`IOCS_LOCK_DATA_BIT]
                && !periph_cfg_reg[`IOCS_LOCK_INH_BIT])
                lock_next = 1'b1;
        end
        if (cycle.active && !cycle.write)
        begin
            if (a == `IOCS_PERIPH_CFG_PORT)
            begin
                rdata_next = periph_cfg_reg;
                rvalid_next = 1'b1;
            end
            if (a == `IOCS_SERIAL_CFG_PORT)
            begin
                rdata_next = {8'h00, serial_cfg_reg};
                rvalid_next = 1'b1;
            end
        end
    end

    // per-cycle decode
    always_comb
    begin
        cs_next = '0;
        exp_next = 1'b0;
        ws_next = `IOCS_WS_NORMAL;
        comp_next = 1'b0;
        ign16_next = 1'b0;
        blocked_next = 1'b0;
        hd_streak_next = hd_streak_reg;
        psw_hit = rtc_index_reg >= `IOCS_PSW_LO
                  && rtc_index_reg <= `IOCS_PSW_HI;
        hd_data = iocs_pkg::io_match(a, pri_sec ? `IOCS_HD_CMD_SEC
                                     : `IOCS_HD_CMD_PRI, 4'h0, full_dec);
        scsi_hit = iocs_pkg::io_match(a, `IOCS_SCSI_BASE, 4'h4, 1'b1);
        video_hit = iocs_pkg::io_match(a, `IOCS_VIDEO_BASE_A, 4'h1, full_dec)
                    || iocs_pkg::io_match(a, `IOCS_VIDEO_BASE_B, 4'h1,
                                          full_dec)
                    || iocs_pkg::io_match(a, `IOCS_VIDEO_BASE_C, 4'h1,
                                          full_dec);
        if (!periph_cfg_reg[`IOCS_HS_DISK_BIT])
            hd_streak_next = 1'b0;
        if (cycle.active)
        begin
            cs_next.serial_a = hit_a;
            cs_next.serial_b = hit_b;
            cs_next.window = hit_win;
            cs_next.video = video_hit;
            if (!periph_cfg_reg[`IOCS_HD_DIS_BIT])
            begin
                cs_next.hd_cmd = iocs_pkg::io_match(a, pri_sec ?
                    `IOCS_HD_CMD_SEC : `IOCS_HD_CMD_PRI, 4'h3, full_dec);
                cs_next.hd_ctl = iocs_pkg::io_match(a, pri_sec ?
                    `IOCS_HD_CTL_SEC : `IOCS_HD_CTL_PRI, 4'h1, full_dec);
            end
            // floppy leaves 3f6/3f7 to the disk control block and never selects there
            if (!periph_cfg_reg[`IOCS_FLP_DIS_BIT])
                cs_next.floppy = iocs_pkg::io_match(a, pri_sec ?
                    `IOCS_FLP_SEC : `IOCS_FLP_PRI, 4'h3, full_dec)
                    && !iocs_pkg::io_match(a, pri_sec ?
                    `IOCS_HD_CTL_SEC : `IOCS_HD_CTL_PRI, 4'h1, full_dec);
            // password bytes: suppress the rtc select on the data port
            if (iocs_pkg::io_match(a, `IOCS_RTC_BASE, 4'h1, full_dec))
            begin
                if (a[0] && lock_reg && psw_hit)
                    blocked_next = 1'b1;
                else
                    cs_next.rtc = 1'b1;
            end
            if (hit_a && serial_cfg_reg[`IOCS_FIRST_SERIAL_SELECT_LOC_BIT])
                exp_next = 1'b1;
            if (hit_b && serial_cfg_reg[`IOCS_SECOND_SERIAL_SELECT_LOC_BIT])
                exp_next = 1'b1;
            if (hit_win && periph_cfg_reg[`IOCS_WIN_LOC_BIT])
                exp_next = 1'b1;
            if (cs_next.rtc && periph_cfg_reg[`IOCS_RTC_LOC_BIT])
                exp_next = 1'b1;
            if (cycle.byte8 && video_hit
                && periph_cfg_reg[`IOCS_FAST_VIDEO_BIT])
                ws_next = `IOCS_WS_ONE;
            if (cycle.byte8 && scsi_hit)
                ws_next = periph_cfg_reg[`IOCS_FAST_SCSI_BIT] ?
                          `IOCS_WS_ONE : `IOCS_WS_FOUR;
            // first 16-bit data transfer runs compatible, later compressed
            if (periph_cfg_reg[`IOCS_HS_DISK_BIT] && cs_next.hd_cmd)
            begin
                if (hd_data && !cycle.byte8)
                begin
                    comp_next = hd_streak_reg;
                    ign16_next = hd_streak_reg;
                    hd_streak_next = 1'b1;
                end
            end
            else
                hd_streak_next = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            periph_cfg_reg <= `IOCS_PERIPH_CFG_RESET;
            serial_cfg_reg <= `IOCS_SERIAL_CFG_RESET;
            lock_reg <= 1'b0;
            rtc_index_reg <= 7'h00;
            hd_streak_reg <= 1'b0;
            cs_reg <= '0;
            exp_reg <= 1'b0;
            ws_reg <= `IOCS_WS_NORMAL;
            comp_reg <= 1'b0;
            ign16_reg <= 1'b0;
            blocked_reg <= 1'b0;
            rdata_reg <= 16'h0000;
            rvalid_reg <= 1'b0;
        end
        else
        begin
            periph_cfg_reg <= periph_cfg_next;
            serial_cfg_reg <= serial_cfg_next;
            lock_reg <= lock_next;
            rtc_index_reg <= rtc_index_next;
            hd_streak_reg <= hd_streak_next;
            cs_reg <= cs_next;
            exp_reg <= exp_next;
            ws_reg <= ws_next;
            comp_reg <= comp_next;
            ign16_reg <= ign16_next;
            blocked_reg <= blocked_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // chip selects are registered and stand for one clock after each active cycle
    assign cs = cs_reg;
    assign expansion_bus_sel = exp_reg;
    assign wait_states = ws_reg;
    assign compressed_timing = comp_reg;
    assign ignore_iocs16 = ign16_reg;
    assign access_blocked = blocked_reg;
    assign io_rdata = rdata_reg;
    assign io_rdata_valid = rvalid_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    first_serial_select_off_a: assert property (
        serial_cfg_reg[7:5] == 3'h0 |=> !cs.serial_a)
        else $error("serial A select while disabled");
    first_serial_select_hit_a: assert property (
        cycle.active && serial_cfg_reg[7:5] == 3'h2 && a[9:3] == 7'h5f
        && (!full_dec || a[15:10] == 6'h00) |=> cs.serial_a)
        else $error("serial A missed 2f8 range");
    second_serial_select_hit_a: assert property (
        cycle.active && serial_cfg_reg[3:1] == 3'h4 && a[9:3] == 7'h5d
        && (!full_dec || a[15:10] == 6'h00) |=> cs.serial_b)
        else $error("serial B missed 2e8 range");
    ser_loc_a: assert property (
        cycle.active && hit_a && serial_cfg_reg[4] |=> expansion_bus_sel)
        else $error("serial A not steered to expansion bus");
    video_wait_a: assert property (
        cycle.active && cycle.byte8 && periph_cfg_reg[14]
        && a == 16'h03c5 |=> wait_states == 3'h1)
        else $error("fast video wait count wrong");
    scsi_slow_a: assert property (
        cycle.active && cycle.byte8 && !periph_cfg_reg[13]
        && a == 16'h3531 |=> wait_states == 3'h4)
        else $error("slow scsi wait count wrong");
    win_off_a: assert property (
        !periph_cfg_reg[12] |=> !cs.window)
        else $error("window select while disabled");
    hd_dis_a: assert property (
        periph_cfg_reg[1] |=> !cs.hd_cmd && !cs.hd_ctl)
        else $error("disk select while disabled");
    flp_dis_a: assert property (
        periph_cfg_reg[0] |=> !cs.floppy)
        else $error("floppy select while disabled");
    lock_inh_a: assert property (
        !lock_reg && periph_cfg_reg[2] |=> !lock_reg)
        else $error("password lock set despite inhibit");
    psw_block_a: assert property (
        cycle.active && lock_reg && a == 16'h0071 && psw_hit
        |=> access_blocked && !cs.rtc)
        else $error("password byte not blocked");
    hs_first_a: assert property (
        !hd_streak_reg |=> !compressed_timing)
        else $error("first disk transfer compressed");
    wide_dec_a: assert property (
        full_dec && a[15:10] != 6'h00 |=> cs.serial_a == 1'b0)
        else $error("16-bit decode ignored upper bits");
    second_serial_select_loc_a: assert property (
        cycle.active && hit_b && serial_cfg_reg[0] |=> expansion_bus_sel)
        else $error("serial B not steered to expansion bus");
    rtc_loc_a: assert property (
        cycle.active && a == 16'h0070 && periph_cfg_reg[15]
        |=> expansion_bus_sel)
        else $error("rtc not steered to expansion bus");
    win_loc_a: assert property (
        cycle.active && hit_win && periph_cfg_reg[7] |=> expansion_bus_sel)
        else $error("window not steered to expansion bus");
    win_hit_a: assert property (
        cycle.active && periph_cfg_reg[12:8] == 5'h1c
        && a[15:4] == window_base[15:4] |=> cs.window)
        else $error("window missed masked match");
    scsi_fast_a: assert property (
        cycle.active && cycle.byte8 && periph_cfg_reg[13]
        && a == 16'h3531 |=> wait_states == 3'h1)
        else $error("fast scsi wait count wrong");
    hs_later_a: assert property (
        cycle.active && !cycle.byte8 && hd_streak_reg && periph_cfg_reg[6]
        && !periph_cfg_reg[1] && !pri_sec && a == 16'h01f0
        |=> compressed_timing && ignore_iocs16)
        else $error("later disk transfer not compressed");
    hd_sel_a: assert property (
        cycle.active && !periph_cfg_reg[1]
        && a == (pri_sec ? 16'h0170 : 16'h01f0) |=> cs.hd_cmd)
        else $error("disk select missed its address");
    flp_sel_a: assert property (
        cycle.active && !periph_cfg_reg[0]
        && a == (pri_sec ? 16'h0372 : 16'h03f2) |=> cs.floppy)
        else $error("floppy select missed its address");
    lock_set_a: assert property (
        cycle.active && cycle.write && a == 16'h0092 && cycle.wdata[3]
        && !periph_cfg_reg[2] |=> lock_reg)
        else $error("password lock not set");
    idle_cs_a: assert property (
        !cycle.active |=> cs == 8'h00)
        else $error("chip select without a cycle");

    burst_c: cover property (compressed_timing[*2]);
    blocked_c: cover property (access_blocked);
    both_ser_c: cover property (cs.serial_a ##[1:4] cs.serial_b);
    win_hit_c: cover property (cs.window && expansion_bus_sel);
    fast_wait_c: cover property (wait_states == 3'h1);
endmodule

// [verif/iocs_host_model.sv]
// host model: issues single I/O cycles on the decoder's cycle input.
// assumes calls come from one process and start off the rising edge.
`timescale 1ns/1ps

module iocs_host_model
(
    input wire logic clk,
    output iocs_pkg::iocs_cycle_t cycle
);
    initial cycle = '0;

    // one access per call, driven at the falling edge, idle afterwards
    task automatic xfer(input logic w, input logic b8,
                        input logic [15:0] a, input logic [15:0] d);
        logic [15:0] dd;
        dd = d;
        // both serial fields on one range gives an undefined answer,
        // so a careful host drops the second one
        if (w && a == 16'h2072 && dd[7:5] == dd[3:1] && dd[3:1] != 3'h0)
            dd[3:1] = 3'h0;
        @(negedge clk);
        cycle = {1'b1, w, b8, a, dd};
        @(negedge clk);
        cycle = '0;
    endtask
endmodule

// [verif/io_port_chip_select_decoder_test.sv]
// self-checking bench for the chip-select decoder with a result queue.
// assumes the host model drives every cycle; window base from here.
`timescale 1ns/1ps

module io_port_chip_select_decoder_test;
    typedef struct packed {
        logic [7:0] csm;
        logic [7:0] cse;
        logic xm;
        logic xe;
        logic [2:0] ws;
        logic hs;
        logic blk;
        logic rv;
        logic [15:0] rd;
    } iocs_exp_t;

    localparam logic [15:0] P1 = 16'h2872;
    localparam logic [15:0] P2 = 16'h2072;
    localparam logic [7:0] C_FL = 8'h80;
    localparam logic [7:0] C_HD = 8'h40;
    localparam logic [7:0] C_SA = 8'h10;
    localparam logic [7:0] C_SB = 8'h08;
    localparam logic [7:0] C_WN = 8'h04;
    localparam logic [7:0] C_RT = 8'h02;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [15:0] base = 16'h0000;
    iocs_pkg::iocs_cycle_t cyc;
    iocs_pkg::iocs_cs_t cs;
    logic expansion_bus_sel;
    logic [2:0] wait_states;
    logic compressed_timing;
    logic ignore_iocs16;
    logic access_blocked;
    logic [15:0] io_rdata;
    logic io_rdata_valid;
    int miscompares = 0;
    int n_compared = 0;
    int seed = 32'h2bf7;
    int b;
    logic act_d = 1'b0;
    logic [15:0] r;
    logic [15:0] ad;
    logic [15:0] sb [4] = '{16'h03f8, 16'h02f8, 16'h03e8, 16'h02e8};
    iocs_exp_t q [$];
    iocs_exp_t em;

    always #5 clk = ~clk;

    iocs_host_model i_host (.clk(clk), .cycle(cyc));

    iocs_decoder i_dut
    (
        .clk(clk),
        .reset(reset),
        .cycle(cyc),
        .window_base(base),
        .cs(cs),
        .expansion_bus_sel(expansion_bus_sel),
        .wait_states(wait_states),
        .compressed_timing(compressed_timing),
        .ignore_iocs16(ignore_iocs16),
        .access_blocked(access_blocked),
        .io_rdata(io_rdata),
        .io_rdata_valid(io_rdata_valid)
    );

    task automatic chk(input string n, input logic [15:0] s,
                       input logic [15:0] e);
        n_compared++;
        if (s !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic tally_and_finish();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    function automatic iocs_exp_t ex(input logic [7:0] m,
        input logic [7:0] c, input logic xm, input logic xe,
        input logic [2:0] ws, input logic hs, input logic blk);
        return {m, c, xm, xe, ws, hs, blk, 1'b0, 16'h0000};
    endfunction

    // note the expectation first, so the watcher always finds it
    task automatic go(input logic w, input logic b8, input logic [15:0] a,
                      input logic [15:0] d, input iocs_exp_t e);
        q.push_back(e);
        i_host.xfer(w, b8, a, d);
    endtask

    task automatic cfg(input logic [15:0] p, input logic [15:0] d);
        go(1'b1, 1'b0, p, d, ex(8'h00, 8'h00, 0, 0, 3'h0, 0, 0));
    endtask

    task automatic rdc(input logic [15:0] p, input logic [15:0] v);
        iocs_exp_t e;
        e = ex(8'h00, 8'h00, 0, 0, 3'h0, 0, 0);
        e.rv = 1'b1;
        e.rd = v;
        go(1'b0, 1'b0, p, 16'h0000, e);
    endtask

    task automatic do_reset();
        @(negedge clk);
        reset = 1'b1;
        repeat (10) @(negedge clk);
        reset = 1'b0;
    endtask

    always @(posedge clk)
    begin
        act_d <= cyc.active & ~reset;
    end

    // results stand one cycle after each active clock
    always @(negedge clk)
    begin
        if (act_d && q.size() == 0)
            chk("queue", 16'h0001, 16'h0000);
        else if (act_d)
        begin
            em = q.pop_front();
            chk("cs", {8'h00, cs & em.csm}, {8'h00, em.cse});
            if (em.xm)
                chk("ext", 16'(expansion_bus_sel), 16'(em.xe));
            chk("ws", 16'(wait_states), 16'(em.ws));
            chk("comp", 16'(compressed_timing), 16'(em.hs));
            chk("ign16", 16'(ignore_iocs16), 16'(em.hs));
            chk("blk", 16'(access_blocked), 16'(em.blk));
            chk("rv", 16'(io_rdata_valid), 16'(em.rv));
            if (em.rv)
                chk("rdata", io_rdata, em.rd);
        end
        else
            chk("idle", {7'h00, io_rdata_valid, cs}, 16'h0000);
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        miscompares++;
        $display("watchdog expired");
        tally_and_finish();
    end

    initial
    begin
        do_reset();
        rdc(P1, 16'h0000);
        rdc(P2, 16'h0000);
        cfg(P1, 16'hffff);
        rdc(P1, 16'hfff7);
        cfg(P2, 16'hffe4);
        rdc(P2, 16'h00e4);
        $display("test registers done");
        for (int a = 0; a < 5; a++)
        begin
            b = (a % 4) + 1; // never the range of the first port
            cfg(P1, {10'h000, a[0], 5'h00});
            cfg(P2, {8'h00, a[2:0], 1'b1, b[2:0], 1'b0});
            for (int k = 1; k < 5; k++)
            begin
                r = 16'($random(seed));
                ad = sb[k - 1] | {a[0] ? 6'h00 : r[15:10], 7'h00, r[2:0]};
                go(0, 0, ad, 0, ex(C_SA | C_SB, (a == k ? C_SA : 8'h00) |
                   (b == k ? C_SB : 8'h00), a == k || b == k, a == k,
                   3'h0, 0, 0));
                if (a[0])
                    go(0, 0, ad | 16'h0400, 0, ex(C_SA | C_SB, 8'h00, 0,
                       0, 3'h0, 0, 0));
            end
        end
        cfg(P2, 16'h0000);
        $display("test serial done");
        for (int lm = 0; lm < 5; lm++)
        begin
            r = 16'($random(seed));
            base = {r[15:10], 6'h2a, r[3:0]};
            cfg(P1, {3'b000, 1'b1, 1'b1, 3'(lm), 1'b1, 7'h00});
            if (lm > 0)
                go(0, 0, base ^ (16'h1 << (lm - 1)), 0,
                   ex(C_WN, C_WN, 1, 1, 3'h0, 0, 0));
            go(0, 0, base ^ (16'h1 << lm), 0,
               ex(C_WN, 8'h00, 0, 0, 3'h0, 0, 0));
            go(0, 0, base ^ 16'h1000, 0,
               ex(C_WN, 8'h00, 0, 0, 3'h0, 0, 0));
            cfg(P1, {3'b000, 1'b1, 1'b0, 3'(lm), 1'b0, 7'h00});
            go(0, 0, base ^ 16'h1000, 0,
               ex(C_WN, C_WN, 1, 0, 3'h0, 0, 0));
            cfg(P1, {3'b000, 1'b0, 1'b0, 3'(lm), 1'b0, 7'h00});
            go(0, 0, base, 0, ex(C_WN, 8'h00, 0, 0, 3'h0, 0, 0));
        end
        $display("test window done");
        for (int s = 0; s < 8; s++)
        begin
            cfg(P1, {11'h000, s[0], 2'b00, s[1], s[2]});
            go(0, 0, s[0] ? 16'h0170 : 16'h01f0, 0, ex(C_HD, s[1] ? 8'h00
               : C_HD, 0, 0, 3'h0, 0, 0));
            go(0, 0, s[0] ? 16'h01f0 : 16'h0170, 0,
               ex(C_HD, 8'h00, 0, 0, 3'h0, 0, 0));
            go(0, 1, s[0] ? 16'h0372 : 16'h03f2, 0, ex(C_FL, s[2] ? 8'h00
               : C_FL, 0, 0, 3'h0, 0, 0));
        end
        $display("test disk selects done");
        for (int f = 0; f < 4; f++)
        begin
            cfg(P1, {1'b0, 2'(f), 13'h0000});
            go(0, 1, 16'h03c1, 0, ex(0, 0, 0, 0, 3'(f[1]), 0, 0));
            go(0, 1, 16'h03ce, 0, ex(0, 0, 0, 0, 3'(f[1]), 0, 0));
            go(0, 1, 16'h03c2, 0, ex(0, 0, 0, 0, 3'h0, 0, 0));
            go(1, 1, 16'h3530 | 16'(f), 0,
               ex(0, 0, 0, 0, f[0] ? 3'h1 : 3'h4, 0, 0));
        end
        $display("test wait states done");
        cfg(P1, 16'h0040);
        for (int i = 0; i < 5; i++)
        begin
            if (i == 3)
                go(0, 1, 16'h0060, 0, ex(0, 0, 0, 0, 3'h0, 0, 0));
            go(0, 0, 16'h01f0, 0, ex(C_HD, C_HD, 0, 0, 3'h0,
               i == 1 || i == 2 || i == 4, 0));
        end
        $display("test high speed disk done");
        cfg(P1, 16'h8000);
        go(1, 1, 16'h0070, 16'h0038, ex(0, 0, 0, 0, 3'h0, 0, 0));
        go(0, 1, 16'h0071, 0, ex(C_RT, C_RT, 1, 1, 3'h0, 0, 0));
        go(1, 1, 16'h0092, 16'h0008, ex(0, 0, 0, 0, 3'h0, 0, 0));
        go(0, 1, 16'h0071, 0, ex(C_RT, 0, 0, 0, 3'h0, 0, 1));
        cfg(P1, 16'h0004);
        go(0, 1, 16'h0071, 0, ex(C_RT, 0, 0, 0, 3'h0, 0, 1));
        for (int x = 0; x < 3; x++)
        begin
            go(1, 1, 16'h0070, x == 0 ? 16'h0037 : x == 1 ? 16'h003f :
               16'h0040, ex(0, 0, 0, 0, 3'h0, 0, 0));
            go(0, 1, 16'h0071, 0, ex(C_RT, x == 1 ? 8'h00 : C_RT, 0, 0,
               3'h0, 0, x == 1));
        end
        do_reset();
        cfg(P1, 16'h0004);
        go(1, 1, 16'h0070, 16'h0038, ex(0, 0, 0, 0, 3'h0, 0, 0));
        go(1, 1, 16'h0092, 16'h0008, ex(0, 0, 0, 0, 3'h0, 0, 0));
        go(0, 1, 16'h0071, 0, ex(C_RT, C_RT, 1, 0, 3'h0, 0, 0));
        $display("test password lock done");
        repeat (3) @(negedge clk);
        tally_and_finish();
    end
endmodule
